// *** logic/sms_pkg.sv ***
// shared constants and types of the spi master/slave controller
package sms_pkg;
    localparam int NUM_CS = 4;
    localparam int CS_W = 2;
    localparam int DATA_W = 16;
    localparam int DIV_W = 8;
    localparam int WORD_W = 32;
    // transmit word field positions
    localparam int TX_DATA_LSB = 0;
    localparam int TX_CS_LSB = 16;
    localparam int LAST_XFER_BIT = 24;
    // word length: field value plus base gives bits per transfer
    localparam logic [4:0] BITS_BASE = 5'h08;
    localparam logic [3:0] BITS_MAX = 4'h8;
    localparam logic [7:0] DIV_ONE = 8'h01;
    localparam logic [5:0] EXTRA_EDGES = 6'h02;
    localparam logic [DATA_W-1:0] ALL_ONES = 16'hFFFF;
    localparam logic [NUM_CS-1:0] CS_NONE = 4'hF;
    localparam logic [NUM_CS-1:0] CS_ONE = 4'h1;

    typedef struct packed {
        logic [DIV_W-1:0] clock_divider;
        logic [3:0] bits;
        logic clock_polarity;
        logic clock_phase_select;
        logic cs_hold_after_xfer;
    } sms_cs_cfg_t;

    typedef enum {ST_IDLE, ST_SHIFT, ST_FINISH, ST_HOLD} sms_state_t;
endpackage

// *** logic/sms_clk_div.sv ***
// half-period enable pulse generator for the serial clock
`timescale 1ns/1ps
module sms_clk_div #(
    parameter int DIV_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);
    initial
    begin
        if (DIV_W < 1 || DIV_W > 16)
        begin
            $error("sms_clk_div: unsupported divider width");
        end
    end

    logic [DIV_W-1:0] cnt;

    // counts div cycles per half period; zero behaves like one
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || restart || !run)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else if (cnt + 1'b1 >= div)
        begin
            cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// *** logic/sms_ctrl.sv ***
// spi master/slave controller core with its documented quirks
// Functional notes
// - odd divider above one, cpol1, phase0: extra pulse
// - hold, divider one, same slave: ready stays low
// - fixed, hold, dma: last flag releases select
// - fixed: dma transfer size follows select zero length
// - divider one with odd length: extra pulse
// - slave mode ignores disable; only reset stops
// - slow then fast select, cpol1, phase0: extra pulse
`timescale 1ns/1ps
module sms_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic soft_reset_cmd,
    input wire logic enable_cmd,
    input wire logic disable_cmd,
    input wire logic master_select,
    input wire logic fixed_mode,
    input wire logic [sms_pkg::CS_W-1:0] fixed_cs,
    input wire logic dma_mode,
    input wire sms_pkg::sms_cs_cfg_t [sms_pkg::NUM_CS-1:0] chip_select_config,
    input wire logic [sms_pkg::WORD_W-1:0] transmit_data_reg,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic transmitter_empty_flag,
    output logic xfer_size_half,
    output logic [sms_pkg::DATA_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic data_in,
    output logic data_out,
    input wire logic slave_select_n,
    output logic [sms_pkg::NUM_CS-1:0] cs_n_o
);
    sms_pkg::sms_state_t state;
    logic ctl_clr, enabled, tick, quirk_used, prev_slow, extra, s_loaded;
    logic sclk_s1, sclk_s2, sclk_s3, ss_s1, ss_s2, din_s1, din_s2;
    logic [sms_pkg::WORD_W-1:0] hold;
    logic [sms_pkg::CS_W-1:0] cur_idx;
    logic cur_last;
    logic [sms_pkg::DATA_W-1:0] tx_sh, rx_sh, next_tx_sh;
    logic [5:0] edge_cnt;
    logic [4:0] s_cnt;
    sms_pkg::sms_cs_cfg_t cur_cfg;

    // soft reset acts like the system reset on all control state
    assign ctl_clr = !rst_n || soft_reset_cmd;

    // word selection and load conditions
    logic [sms_pkg::CS_W-1:0] sel_idx;
    sms_pkg::sms_cs_cfg_t sel_cfg, cfg0;
    logic load_m, dup_quirk, div_one, odd_quirk, len_quirk, mix_quirk;
    logic [4:0] sel_bits, cur_bits;
    logic [5:0] total_edges;
    logic capture, s_active, s_lead, s_edge, s_sample;
    assign sel_idx = fixed_mode ? fixed_cs : hold[sms_pkg::TX_CS_LSB +: sms_pkg::CS_W];
    assign sel_cfg = chip_select_config[sel_idx];
    assign cfg0 = chip_select_config[0];
    assign sel_bits = sms_pkg::BITS_BASE + {1'b0, sel_cfg.bits};
    assign cur_bits = sms_pkg::BITS_BASE + {1'b0, cur_cfg.bits};
    assign load_m = master_select && enabled && state != sms_pkg::ST_SHIFT
        && state != sms_pkg::ST_FINISH && !tx_ready;
    assign div_one = sel_cfg.clock_divider == sms_pkg::DIV_ONE;
    assign dup_quirk = load_m && state == sms_pkg::ST_HOLD && sel_idx == cur_idx
        && sel_cfg.cs_hold_after_xfer && div_one && !quirk_used;
    assign odd_quirk = sel_cfg.clock_divider[0] && !div_one
        && sel_cfg.clock_polarity && !sel_cfg.clock_phase_select;
    assign len_quirk = div_one && sel_cfg.bits[0];
    assign mix_quirk = div_one && prev_slow && sel_cfg.clock_polarity && !sel_cfg.clock_phase_select;
    assign total_edges = {cur_bits, 1'b0} + (extra ? sms_pkg::EXTRA_EDGES : 6'h00);
    assign capture = edge_cnt[0] != cur_cfg.clock_phase_select;
    assign s_active = !master_select && enabled && !ss_s2;
    assign s_edge = sclk_s2 != sclk_s3;
    assign s_lead = s_edge && sclk_s2 != cfg0.clock_polarity;
    assign s_sample = s_edge && (cfg0.clock_phase_select ? s_lead : !s_lead);

    sms_clk_div #(.DIV_W(sms_pkg::DIV_W)) u_div (
        .clk_sys(clk_sys),
        .rst_n(!ctl_clr),
        .run(state == sms_pkg::ST_SHIFT),
        .restart(load_m),
        .div(cur_cfg.clock_divider),
        .tick(tick)
    );

    // pin synchronisers for slave clock, select and serial input
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {ss_s1, ss_s2, din_s1, din_s2} <= 4'hF;
        end
        else
        begin
            sclk_s1 <= serial_clock_pin_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            ss_s1 <= slave_select_n;
            ss_s2 <= ss_s1;
            din_s1 <= data_in;
            din_s2 <= din_s1;
        end
    end

    // enable; disable only takes effect in master operation
    always_ff @(posedge clk_sys)
    begin
        if (ctl_clr)
            enabled <= 1'b0;
        else if (enable_cmd)
            enabled <= 1'b1;
        else if (disable_cmd && master_select)
            enabled <= 1'b0;
    end

    // holding register and transmit-ready handshake
    always_ff @(posedge clk_sys)
    begin
        if (ctl_clr)
        begin
            hold <= '0;
            tx_ready <= 1'b1;
            quirk_used <= 1'b0;
        end
        else if (load_m)
        begin
            tx_ready <= dup_quirk ? 1'b0 : 1'b1;
            quirk_used <= dup_quirk;
        end
        else if (!master_select && s_active && !s_loaded && !tx_ready)
            tx_ready <= 1'b1;
        else if (tx_valid && tx_ready)
        begin
            hold <= transmit_data_reg;
            tx_ready <= 1'b0;
        end
    end

    // master sequencer, select outputs and clock level
    always_ff @(posedge clk_sys)
    begin
        if (ctl_clr)
        begin
            state <= sms_pkg::ST_IDLE;
            cs_n_o <= sms_pkg::CS_NONE;
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            cur_idx <= '0;
            cur_cfg <= '0;
            cur_last <= 1'b0;
            extra <= 1'b0;
            prev_slow <= 1'b0;
            edge_cnt <= '0;
        end
        else
        begin
            serial_clock_pin_oe <= master_select;
            if (load_m)
            begin
                state <= sms_pkg::ST_SHIFT;
                cur_idx <= sel_idx;
                cur_cfg <= sel_cfg;
                cur_last <= hold[sms_pkg::LAST_XFER_BIT];
                extra <= odd_quirk || len_quirk || mix_quirk;
                prev_slow <= !div_one;
                edge_cnt <= '0;
                cs_n_o <= ~(sms_pkg::CS_ONE << sel_idx);
                serial_clock_pin_o <= sel_cfg.clock_polarity;
            end
            else if (state == sms_pkg::ST_SHIFT && tick)
            begin
                serial_clock_pin_o <= ~serial_clock_pin_o;
                edge_cnt <= edge_cnt + 6'h01;
                if (edge_cnt == total_edges - 6'h01)
                    state <= sms_pkg::ST_FINISH;
            end
            else if (state == sms_pkg::ST_FINISH)
            begin
                if (cur_cfg.cs_hold_after_xfer && !(cur_last && (!fixed_mode || dma_mode)))
                    state <= sms_pkg::ST_HOLD;
                else
                begin
                    state <= sms_pkg::ST_IDLE;
                    cs_n_o <= sms_pkg::CS_NONE;
                end
            end
            else if (state == sms_pkg::ST_IDLE)
                serial_clock_pin_o <= master_select ? sel_cfg.clock_polarity : 1'b0;
        end
    end

    // shift path shared by master and slave operation
    always_comb
    begin
        next_tx_sh = tx_sh;
        if (load_m)
            next_tx_sh = hold[sms_pkg::TX_DATA_LSB +: sms_pkg::DATA_W] << (5'h10 - sel_bits);
        else if (master_select && state == sms_pkg::ST_SHIFT && tick && edge_cnt < {cur_bits, 1'b0}
            && !capture && edge_cnt != 6'h00)
            next_tx_sh = {tx_sh[sms_pkg::DATA_W-2:0], 1'b0};
        else if (s_active && !s_loaded)
            next_tx_sh = tx_ready ? '0 : hold[sms_pkg::TX_DATA_LSB +: sms_pkg::DATA_W]
                << (5'h10 - (sms_pkg::BITS_BASE + {1'b0, cfg0.bits}));
        else if (s_active && s_edge && !s_sample && s_cnt != 5'h00)
            next_tx_sh = {tx_sh[sms_pkg::DATA_W-2:0], 1'b0};
    end

    // shift registers, received word and slave bit count
    always_ff @(posedge clk_sys)
    begin
        if (ctl_clr)
        begin
            tx_sh <= '0;
            rx_sh <= '0;
            data_out <= 1'b0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            s_cnt <= '0;
            s_loaded <= 1'b0;
        end
        else
        begin
            tx_sh <= next_tx_sh;
            data_out <= next_tx_sh[sms_pkg::DATA_W-1];
            rx_valid <= 1'b0;
            if (master_select && state == sms_pkg::ST_SHIFT && tick && edge_cnt < {cur_bits, 1'b0} && capture)
                rx_sh <= {rx_sh[sms_pkg::DATA_W-2:0], din_s2};
            else if (master_select && state == sms_pkg::ST_FINISH)
            begin
                rx_data <= rx_sh & (sms_pkg::ALL_ONES >> (5'h10 - cur_bits));
                rx_valid <= 1'b1;
            end
            if (!s_active)
            begin
                s_cnt <= '0;
                s_loaded <= 1'b0;
            end
            else
            begin
                s_loaded <= 1'b1;
                if (s_sample && s_loaded)
                begin
                    rx_sh <= {rx_sh[sms_pkg::DATA_W-2:0], din_s2};
                    s_cnt <= s_cnt + 5'h01;
                    if (s_cnt == sms_pkg::BITS_BASE + {1'b0, cfg0.bits} - 5'h01)
                    begin
                        rx_data <= {rx_sh[sms_pkg::DATA_W-2:0], din_s2}
                            & (sms_pkg::ALL_ONES >> (5'h10 - sms_pkg::BITS_BASE - {1'b0, cfg0.bits}));
                        rx_valid <= 1'b1;
                        s_cnt <= '0;
                        s_loaded <= 1'b0;
                    end
                end
            end
        end
    end

    // status flags and dma transfer size
    always_ff @(posedge clk_sys)
    begin
        if (ctl_clr)
        begin
            transmitter_empty_flag <= 1'b1;
            xfer_size_half <= 1'b0;
        end
        else
        begin
            transmitter_empty_flag <= tx_ready && state != sms_pkg::ST_SHIFT && state != sms_pkg::ST_FINISH;
            if (fixed_mode)
                xfer_size_half <= cfg0.bits != 4'h0;
            else
                xfer_size_half <= sel_cfg.bits != 4'h0;
        end
    end

    // helper: count of serial clock toggles in the current transfer
    logic [5:0] tgl_cnt;
    always_ff @(posedge clk_sys)
    begin
        if (ctl_clr || load_m)
            tgl_cnt <= '0;
        else if (state == sms_pkg::ST_SHIFT && tick)
            tgl_cnt <= tgl_cnt + 6'h01;
    end

    sequence s_finish_released;
        state == sms_pkg::ST_FINISH ##1 cs_n_o == sms_pkg::CS_NONE;
    endsequence

    a_odd_div_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == sms_pkg::ST_FINISH && cur_cfg.clock_divider[0] && cur_cfg.clock_divider != sms_pkg::DIV_ONE
        && cur_cfg.clock_polarity && !cur_cfg.clock_phase_select) |-> tgl_cnt == {cur_bits, 1'b0} + 6'h02)
        else $error("odd divider extra pulse missing");
    a_dup_ready_low: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_reset_cmd)
        dup_quirk |=> !tx_ready)
        else $error("ready rose after duplicated load");
    a_ready_after_load: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_reset_cmd)
        (load_m && !dup_quirk) |=> tx_ready)
        else $error("ready missing after normal load");
    a_last_release: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_reset_cmd)
        (state == sms_pkg::ST_FINISH && cur_last && fixed_mode && dma_mode) |-> s_finish_released)
        else $error("select not released on last transfer");
    a_size_cs0: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_reset_cmd)
        (fixed_mode && dma_mode) |=> xfer_size_half == ($past(cfg0.bits) != 4'h0))
        else $error("dma size not following select zero");
    a_len_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == sms_pkg::ST_FINISH && cur_cfg.clock_divider == sms_pkg::DIV_ONE && !cur_cfg.bits[0]
        && !cur_cfg.clock_polarity) |-> tgl_cnt == {cur_bits, 1'b0})
        else $error("even length at divider one has wrong pulse count");
    a_mix_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_reset_cmd)
        (load_m && mix_quirk) |=> extra)
        else $error("slow to fast select lacks extra pulse");
    a_slave_no_disable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enabled && !master_select && disable_cmd && !soft_reset_cmd && !enable_cmd) |=> enabled)
        else $error("slave disabled by disable command");
    a_soft_reset_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset_cmd |=> (state == sms_pkg::ST_IDLE && cs_n_o == sms_pkg::CS_NONE && tx_ready && !enabled))
        else $error("soft reset did not clear controller");
    a_cs_in_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == sms_pkg::ST_SHIFT) |-> cs_n_o != sms_pkg::CS_NONE)
        else $error("select released during shifting");
endmodule

// *** sim/sms_slave_model.sv ***
// behavioural serial slave that counts clock edges and captures the master's data
`timescale 1ns/1ps
module sms_slave_model (
    input wire logic clk_sys,
    input wire logic [sms_pkg::NUM_CS-1:0] cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic capture_phase,
    output logic miso,
    output int edges,
    output logic [31:0] shreg
);
    logic cs_q = 1'b1;
    logic sclk_q = 1'b0;
    initial miso = 1'b0;
    initial edges = 0;
    initial shreg = 32'h0;
    // edge count restarts on select fall; capture edge parity follows the phase setting
    always @(posedge clk_sys)
    begin
        if (!(&cs_n) && cs_q)
            edges <= 0;
        else if (!(&cs_n) && sclk != sclk_q)
        begin
            edges <= edges + 1;
            if (((edges + 1) % 2 == 1) == capture_phase)
                shreg <= {shreg[30:0], mosi};
        end
        cs_q <= &cs_n;
        sclk_q <= sclk;
    end
    // unselected the line changes every cycle so a stale value is never mistaken for data
    always @(posedge clk_sys)
    begin
        if (&cs_n)
            miso <= ~miso;
        else if (sclk != sclk_q)
            miso <= shreg[0] ^ edges[0];
    end
endmodule

// *** sim/tb_spi_master_slave_controller.sv ***
// self-checking bench of the spi master/slave controller
`timescale 1ns/1ps
module tb_spi_master_slave_controller;
    logic clk_sys = 1'b0, rst_n = 1'b0, soft_reset_cmd = 1'b0, enable_cmd = 1'b0, disable_cmd = 1'b0;
    logic master_select = 1'b1, fixed_mode = 1'b0, dma_mode = 1'b0, tx_valid = 1'b0;
    logic [1:0] fixed_cs = 2'h0;
    sms_pkg::sms_cs_cfg_t [sms_pkg::NUM_CS-1:0] cfg = '0;
    logic [31:0] transmit_data_reg = 32'h0;
    logic tx_ready, empty_flag, size_half, rx_valid, sclk_o, sclk_oe, data_out, data_in, miso, cur_ph = 1'b1;
    logic sclk_i = 1'b0, ssel_n = 1'b1, tb_mosi = 1'b0;
    logic [15:0] rx_data;
    logic [3:0] cs_n_o;
    logic [31:0] shreg;
    logic [15:0] rx_q[$];
    int edges, err_count = 0, total_checks = 0, rx_cnt = 0, cyc = 0, prev_div = 1;
    sms_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .soft_reset_cmd(soft_reset_cmd), .enable_cmd(enable_cmd),
        .disable_cmd(disable_cmd), .master_select(master_select), .fixed_mode(fixed_mode), .fixed_cs(fixed_cs),
        .dma_mode(dma_mode), .chip_select_config(cfg), .transmit_data_reg(transmit_data_reg), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .transmitter_empty_flag(empty_flag), .xfer_size_half(size_half), .rx_data(rx_data),
        .rx_valid(rx_valid), .serial_clock_pin_i(sclk_i), .serial_clock_pin_o(sclk_o),
        .serial_clock_pin_oe(sclk_oe), .data_in(data_in), .data_out(data_out), .slave_select_n(ssel_n),
        .cs_n_o(cs_n_o));
    sms_slave_model slv (.clk_sys(clk_sys), .cs_n(cs_n_o), .sclk(sclk_o), .mosi(data_out),
        .capture_phase(cur_ph), .miso(miso), .edges(edges), .shreg(shreg));
    // serial input comes from the slave model as master, from the bench as slave
    assign data_in = master_select ? miso : tb_mosi;
    // 125 MHz system clock
    initial forever #4 clk_sys = ~clk_sys;
    // received words queue and a changing line while the bench's slave select is off
    always @(negedge clk_sys)
    begin
        if (rx_valid === 1'b1)
        begin
            rx_q.push_back(rx_data);
            rx_cnt++;
        end
        if (ssel_n)
            tb_mosi = ~tb_mosi;
    end
    // hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic setcfg(input int cs, input int d, input int b, input int cp, input int ph, input int h);
        cfg[cs].clock_divider = 8'(d);
        cfg[cs].bits = 4'(b);
        cfg[cs].clock_polarity = 1'(cp);
        cfg[cs].clock_phase_select = 1'(ph);
        cfg[cs].cs_hold_after_xfer = 1'(h);
    endtask
    task automatic cmd(input logic dis);
        @(negedge clk_sys);
        enable_cmd = ~dis;
        disable_cmd = dis;
        @(negedge clk_sys);
        enable_cmd = 1'b0;
        disable_cmd = 1'b0;
    endtask
    task automatic sreset();
        repeat (2)
        begin
            @(negedge clk_sys);
            soft_reset_cmd = 1'b1;
            @(negedge clk_sys);
            soft_reset_cmd = 1'b0;
        end
    endtask
    task automatic send(input logic [31:0] w);
        int k;
        @(negedge clk_sys);
        transmit_data_reg = w;
        tx_valid = 1'b1;
        for (k = 0; k < 3000 && tx_ready !== 1'b1; k++)
            @(negedge clk_sys);
        if (k == 3000)
            err_count++;
        @(negedge clk_sys);
        tx_valid = 1'b0;
    endtask
    task automatic wait_rx(input int n0);
        int k;
        for (k = 0; k < 3000 && rx_cnt <= n0; k++)
            @(negedge clk_sys);
        if (k == 3000)
            err_count++;
    endtask
    // one master word; edges expected from the divider, length, mode and previous divider
    task automatic run(input int cs, input int d, input int b, input int cp, input int ph);
        logic [31:0] w, mask;
        int n, e, len, dd;
        setcfg(cs, d, b, cp, ph, 0);
        len = 8 + b;
        dd = (d == 0) ? 1 : d;
        e = 2 * len;
        if ((dd % 2 == 1 && dd != 1 && cp == 1 && ph == 0) || (dd == 1 && len % 2 == 1)
            || (dd == 1 && cp == 1 && ph == 0 && prev_div != 1))
            e = e + 2;
        mask = (32'h1 << len) - 32'h1;
        w = {14'h0, 2'(cs), 16'($urandom)};
        cur_ph = 1'(ph);
        n = rx_cnt;
        send(w);
        wait_rx(n);
        repeat (2) @(negedge clk_sys);
        chk(32'(edges), 32'(e));
        if (e == 2 * len)
            chk(shreg & mask, w & mask);
        prev_div = dd;
    endtask
    // bench drives a slave frame, mode with capture on the leading edge
    task automatic sframe(input logic [7:0] b);
        int i;
        @(negedge clk_sys);
        ssel_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (i = 7; i >= 0; i--)
        begin
            tb_mosi = b[i];
            repeat (6) @(negedge clk_sys);
            sclk_i = 1'b1;
            repeat (6) @(negedge clk_sys);
            sclk_i = 1'b0;
        end
        repeat (6) @(negedge clk_sys);
        ssel_n = 1'b1;
    endtask
    // main sequence
    initial
    begin
        int i, n, k;
        int tdv[5], tbt[5], tcp[5], tph[5];
        logic [7:0] sb;
        tdv = '{3, 2, 1, 1, 5};
        tbt = '{0, 0, 1, 0, 3};
        tcp = '{1, 1, 0, 0, 1};
        tph = '{0, 0, 1, 1, 0};
        void'($urandom(36609));
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk(32'(cs_n_o), 32'(sms_pkg::CS_NONE));
        chk(32'({tx_ready, empty_flag, sclk_o, sclk_oe}), 32'hD);
        master_select = 1'b1;
        cmd(1'b0);
        for (i = 0; i < 5; i++)
            run(i % 4, tdv[i], tbt[i], tcp[i], tph[i]);
        for (i = 0; i < 3; i++)
            run(i, 2 + $urandom % 5, $urandom % 9, $urandom % 2, 1);
        run(1, 2, 0, 1, 0);
        run(0, 1, 0, 1, 0);
        // size output in fixed dma mode follows select zero
        fixed_mode = 1'b1;
        dma_mode = 1'b1;
        fixed_cs = 2'h1;
        setcfg(0, 4, 2, 0, 1, 0);
        setcfg(1, 4, 0, 0, 1, 0);
        n = rx_cnt;
        send(32'h0001_00A5);
        wait_rx(n);
        chk(32'(size_half), 32'h1);
        setcfg(0, 4, 0, 0, 1, 0);
        n = rx_cnt;
        send(32'h0001_005A);
        wait_rx(n);
        chk(32'(size_half), 32'h0);
        // held select released by the last flag
        setcfg(1, 4, 0, 0, 1, 1);
        n = rx_cnt;
        send(32'h0001_0033);
        wait_rx(n);
        repeat (3) @(negedge clk_sys);
        chk(32'(cs_n_o), 32'hD);
        n = rx_cnt;
        send(32'h0101_00CC);
        wait_rx(n);
        repeat (3) @(negedge clk_sys);
        chk(32'(cs_n_o), 32'(sms_pkg::CS_NONE));
        // select one goes back to releasing its select after each transfer
        setcfg(1, 4, 0, 0, 1, 0);
        // hold with divider one: second word to the same select goes out twice
        fixed_mode = 1'b0;
        dma_mode = 1'b0;
        sreset();
        cmd(1'b0);
        setcfg(2, 1, 0, 0, 1, 1);
        n = rx_cnt;
        send(32'h0002_0011);
        wait_rx(n);
        repeat (4) @(negedge clk_sys);
        n = rx_cnt;
        send(32'h0102_0022);
        repeat (150) @(negedge clk_sys);
        chk(32'(rx_cnt - n), 32'h2);
        setcfg(2, 1, 0, 0, 1, 0);
        // soft reset in mid transfer
        setcfg(0, 8, 8, 0, 1, 0);
        cmd(1'b0);
        send(32'h0000_BEEF);
        for (k = 0; k < 100 && (&cs_n_o); k++)
            @(negedge clk_sys);
        repeat (20) @(negedge clk_sys);
        chk(32'(cs_n_o), 32'hE);
        sreset();
        chk(32'(cs_n_o), 32'(sms_pkg::CS_NONE));
        chk(32'({tx_ready, empty_flag, sclk_o, rx_valid, sclk_oe}), 32'h18);
        // slave mode keeps running through a disable
        master_select = 1'b0;
        sreset();
        cmd(1'b0);
        cmd(1'b1);
        setcfg(0, 4, 0, 0, 1, 0);
        sb = 8'($urandom);
        n = rx_cnt;
        sframe(sb);
        wait_rx(n);
        chk(32'(rx_q[$]), 32'(sb));
        void'(rx_q.pop_back());
        sreset();
        n = rx_cnt;
        sframe(8'h5A);
        repeat (20) @(negedge clk_sys);
        chk(32'(rx_cnt), 32'(n));
        end_sim();
    end
endmodule
